/* File: cpu_flags_consts.vh */
// Purpose: constants for the condition-code and interrupt-priority unit
// Assumes: 8-bit core, 40 MHz clock
// Notes:   definitions only
`ifndef CPU_FLAGS_CONSTS_VH
`define CPU_FLAGS_CONSTS_VH

`define CC_BIT_CARRY    0
`define CC_BIT_ZERO     1
`define CC_BIT_NEG      2
`define CC_BIT_PRIO_LO  3
`define CC_BIT_HALF     4
`define CC_BIT_PRIO_HI  5
`define CC_RESET        8'hE8
`define NUM_SRC         14
`define NUM_SPR         4
`define SPR_RESET       8'hFF
`define PC_RESET        16'h0000
`define ACC_RESET       8'h00

// Priority bit pairs {hi,lo}
`define LVL0_BITS       2'h2
`define LVL1_BITS       2'h1
`define LVL2_BITS       2'h0
`define LVL3_BITS       2'h3

// ALU operations
`define OP_NONE   4'h0
`define OP_ADD    4'h1
`define OP_ADC    4'h2
`define OP_SUB    4'h3
`define OP_SBC    4'h4
`define OP_LOGIC  4'h5
`define OP_MOVE   4'h6
`define OP_SHIFT  4'h7
`define OP_BTJ    4'h8

// Control instructions
`define CI_NONE    4'h0
`define CI_SCF     4'h1
`define CI_RCF     4'h2
`define CI_RIM     4'h3
`define CI_SIM     4'h4
`define CI_RETURN_FROM_IRQ_INSTR    4'h5
`define CI_HALT    4'h6
`define CI_WFI     4'h7
`define CI_POP_CC  4'h8

// Branch conditions
`define BR_H   3'h0
`define BR_NH  3'h1
`define BR_MI  3'h2
`define BR_PL  3'h3
`define BR_EQ  3'h4
`define BR_NE  3'h5
`define BR_C   3'h6
`define BR_NC  3'h7

`endif

/* File: cpu_flags_and_irq_priority.v */
// Purpose: condition-code flags, software priority and interrupt selection
// Assumes: sources indexed 0 highest .. 13; top-level input above all
// Notes on behaviour
// - Add and add-with-carry set half-carry on bit3-to-bit4 carry, else clear.
// - Negative flag at bit 2 copies result bit 7.
// - Zero flag at bit 1 is set when the result equals zero.
// - Carry at bit 0 shows arithmetic overflow or underflow.
// - Set/reset-carry force carry; bit-test, shift, rotate update it.
// - Each flag has a branch-condition pair evaluated here.
// - Priority bits 5 and 3 encode levels 0..3; level 3 disables.
// - Interrupt entry loads priority bits from that source's field.
// - Enable, disable, return, halt, wait and pop change priority bits.
// - Whole register pushed to and popped from the stack.
// - No memory map; reached only through instruction ports.
// - Accumulator is an 8-bit operand and result register.
// - Entry and exit context save leaves second index register alone.
// - Program counter is 16 bits of low and high byte.
// - Any interrupt wakes wait; only halt-capable ones and the top-level input wake halt.
// - After halt the first serviced interrupt is halt-capable or the top-level one.
// - Non-halt-capable pending one is serviced after the first.
// - Concurrent mode never preempts; nested mode lets higher preempt.
// - Fixed order: main, sources high index to zero, then top level.
// - No stack overflow signal is provided.
// - Each source owns a two-bit field; fields reset to level 3.
`include "cpu_flags_consts.vh"
`timescale 1ns/1ps

module cpu_flags_and_irq_priority (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_reset_n,
	// ALU operation, operands, shift carry and accumulator write
	input  wire [3:0]  i_alu_op,
	input  wire [7:0]  i_alu_a,
	input  wire [7:0]  i_alu_b,
	input  wire        i_shift_carry,
	input  wire        i_acc_we,
	// Control instructions
	input  wire [3:0]  i_ctrl_instr,
	input  wire [7:0]  i_pop_data,
	input  wire [1:0]  i_rim_level,
	input  wire [2:0]  i_branch_cond,
	// Software priority registers
	input  wire        i_spr_we,
	input  wire [1:0]  i_spr_sel,
	input  wire [7:0]  i_spr_wdata,
	// Interrupt sources
	input  wire [13:0] i_irq_pending,
	input  wire [13:0] i_irq_halt_cap,
	input  wire        i_top_level_interrupt,
	input  wire        i_nested_mode,
	input  wire        i_irq_ack,
	// Program counter
	input  wire        i_pc_we,
	input  wire [15:0] i_pc_wdata,
	// Outputs
	output reg  [7:0]  o_condition_code,
	output reg  [7:0]  o_acc,
	output reg  [15:0] o_pc,
	output reg         o_branch_taken,
	output reg         o_irq_req,
	output reg  [3:0]  o_irq_id,
	output reg         o_irq_top,
	output reg         o_halted,
	output reg         o_waiting,
	output reg  [31:0] o_spr
);

	reg  [7:0]  cc_reg;
	reg  [7:0]  cc_next;
	reg  [7:0]  acc_reg;
	reg  [15:0] pc_reg;
	reg  [7:0]  spr_reg [0:`NUM_SPR-1];
	reg         halt_reg;
	reg         wait_reg;
	reg         in_isr_reg;
	reg  [1:0]  level_reg [0:`NUM_SRC-1];
	wire [8:0]  sum;
	wire [4:0]  half_sum;
	wire [8:0]  diff;
	wire        cin;
	wire [7:0]  res;
	reg  [1:0]  cur_rank;
	reg         found;
	reg  [3:0]  sel_id;
	reg  [1:0]  sel_rank;
	reg         sel_top;
	reg         take;
	integer     k;
	integer     j;

	// Priority bits to rank: level 0 -> 0 .. level 3 -> 3
	function [1:0] rank_of;
		input [1:0] bits;
		begin
			case (bits)
			`LVL0_BITS: rank_of = 2'h0;
			`LVL1_BITS: rank_of = 2'h1;
			`LVL2_BITS: rank_of = 2'h2;
			default:    rank_of = 2'h3;
			endcase
		end
	endfunction

	// Carry in only for the with-carry forms
	assign cin = (i_alu_op == `OP_ADC || i_alu_op == `OP_SBC) ?
		cc_reg[`CC_BIT_CARRY] : 1'b0;
	assign sum = {1'b0, i_alu_a} + {1'b0, i_alu_b} + {8'h00, cin};
	assign half_sum = {1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]} +
		{4'h0, cin};
	assign diff = {1'b0, i_alu_a} - {1'b0, i_alu_b} - {8'h00, cin};
	assign res = (i_alu_op == `OP_ADD || i_alu_op == `OP_ADC) ? sum[7:0] :
		(i_alu_op == `OP_SUB || i_alu_op == `OP_SBC) ? diff[7:0] : i_alu_a;

	// Per-source two-bit fields, four to a register
	genvar g;
	generate
		for (g = 0; g < `NUM_SRC; g = g + 1) begin : g_field
			always @* begin
				level_reg[g] = spr_reg[g/4][(g%4)*2 +: 2];
			end
		end
	endgenerate

	// Selection: scan sources 13..0 so index 0 wins ties
	always @* begin
		cur_rank = rank_of({cc_reg[`CC_BIT_PRIO_HI], cc_reg[`CC_BIT_PRIO_LO]});
		found = 1'b0;
		sel_id = 4'h0;
		sel_rank = 2'h0;
		sel_top = 1'b0;
		take = 1'b0;
		for (k = `NUM_SRC - 1; k >= 0; k = k - 1) begin
			if (i_irq_pending[k] && (!halt_reg || i_irq_halt_cap[k]) &&
				(!found || rank_of(level_reg[k]) >= sel_rank)) begin
				found = 1'b1;
				sel_id = k[3:0];
				sel_rank = rank_of(level_reg[k]);
			end
		end
		if (i_top_level_interrupt) begin
			found = 1'b1;
			sel_top = 1'b1;
			sel_rank = 2'h3;
		end
		// Pending ones lacking halt capability wait
		take = found && (sel_top || (sel_rank > cur_rank)) &&
			(!in_isr_reg || i_nested_mode);
	end

	// Next flags: ALU first, then control instructions, then entry
	always @* begin
		cc_next = cc_reg;
		case (i_alu_op)
		`OP_ADD, `OP_ADC: begin
			cc_next[`CC_BIT_HALF] = half_sum[4];
			cc_next[`CC_BIT_CARRY] = sum[8];
		end
		`OP_SUB, `OP_SBC: cc_next[`CC_BIT_CARRY] = diff[8];
		`OP_SHIFT, `OP_BTJ: cc_next[`CC_BIT_CARRY] = i_shift_carry;
		default: cc_next = cc_reg;
		endcase
		if (i_alu_op != `OP_NONE && i_alu_op != `OP_BTJ) begin
			cc_next[`CC_BIT_NEG] = res[7];
			cc_next[`CC_BIT_ZERO] = (res == 8'h00);
		end
		case (i_ctrl_instr)
		`CI_SCF: cc_next[`CC_BIT_CARRY] = 1'b1;
		`CI_RCF: cc_next[`CC_BIT_CARRY] = 1'b0;
		`CI_RIM, `CI_HALT, `CI_WFI: begin
			cc_next[`CC_BIT_PRIO_HI] = i_rim_level[1];
			cc_next[`CC_BIT_PRIO_LO] = i_rim_level[0];
		end
		`CI_SIM: begin
			cc_next[`CC_BIT_PRIO_HI] = 1'b1;
			cc_next[`CC_BIT_PRIO_LO] = 1'b1;
		end
		`CI_RETURN_FROM_IRQ_INSTR, `CI_POP_CC: cc_next = i_pop_data;
		default: ;
		endcase
		if (i_irq_ack && take && !sel_top) begin
			cc_next[`CC_BIT_PRIO_HI] = level_reg[sel_id][1];
			cc_next[`CC_BIT_PRIO_LO] = level_reg[sel_id][0];
		end else if (i_irq_ack && take) begin
			cc_next[`CC_BIT_PRIO_HI] = 1'b1;
			cc_next[`CC_BIT_PRIO_LO] = 1'b1;
		end
	end

	// Branch decision registered against the flags now held
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_branch_taken <= 1'b0;
		end else begin
			case (i_branch_cond)
			`BR_H:   o_branch_taken <= cc_reg[`CC_BIT_HALF];
			`BR_NH:  o_branch_taken <= !cc_reg[`CC_BIT_HALF];
			`BR_MI:  o_branch_taken <= cc_reg[`CC_BIT_NEG];
			`BR_PL:  o_branch_taken <= !cc_reg[`CC_BIT_NEG];
			`BR_EQ:  o_branch_taken <= cc_reg[`CC_BIT_ZERO];
			`BR_NE:  o_branch_taken <= !cc_reg[`CC_BIT_ZERO];
			`BR_C:   o_branch_taken <= cc_reg[`CC_BIT_CARRY];
			default: o_branch_taken <= !cc_reg[`CC_BIT_CARRY];
			endcase
		end
	end

	// Flags, accumulator and program counter
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			cc_reg  <= `CC_RESET;
			acc_reg <= `ACC_RESET;
			pc_reg  <= `PC_RESET;
		end else begin
			cc_reg <= cc_next;
			if (i_acc_we)
				acc_reg <= res;
			if (i_pc_we)
				pc_reg <= i_pc_wdata;
		end
	end

	// Software priority registers
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			for (j = 0; j < `NUM_SPR; j = j + 1)
				spr_reg[j] <= `SPR_RESET;
		end else if (i_spr_we) begin
			spr_reg[i_spr_sel] <= i_spr_wdata;
		end
	end

	// Registered offer to the core
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_irq_req <= 1'b0;
			o_irq_id  <= 4'h0;
			o_irq_top <= 1'b0;
		end else begin
			o_irq_req <= take;
			o_irq_id  <= sel_id;
			o_irq_top <= sel_top;
		end
	end

	// In-service flag: set on entry, cleared by return from interrupt
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			in_isr_reg <= 1'b0;
		end else if (i_irq_ack && take) begin
			in_isr_reg <= 1'b1;
		end else if (i_ctrl_instr == `CI_RETURN_FROM_IRQ_INSTR) begin
			in_isr_reg <= 1'b0;
		end
	end

	// Halt ends only on entry, so the halt-capable filter
	// stays on until the first wake source is serviced
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			halt_reg <= 1'b0;
			wait_reg <= 1'b0;
		end else if (i_irq_ack && take) begin
			halt_reg <= 1'b0;
			wait_reg <= 1'b0;
		end else begin
			if (i_ctrl_instr == `CI_HALT)
				halt_reg <= 1'b1;
			if (i_ctrl_instr == `CI_WFI)
				wait_reg <= 1'b1;
			if (found && wait_reg)
				wait_reg <= 1'b0;
		end
	end

	// Registered copies of internal state
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_condition_code <= `CC_RESET;
			o_acc            <= `ACC_RESET;
			o_pc             <= `PC_RESET;
			o_halted         <= 1'b0;
			o_waiting        <= 1'b0;
			o_spr            <= {`NUM_SPR{`SPR_RESET}};
		end else begin
			o_condition_code <= cc_reg;
			o_acc            <= acc_reg;
			o_pc             <= pc_reg;
			o_halted         <= halt_reg;
			o_waiting        <= wait_reg;
			o_spr            <= {spr_reg[3], spr_reg[2], spr_reg[1],
				spr_reg[0]};
		end
	end

	// No stack depth is tracked, so nesting overflow goes unseen

endmodule // cpu_flags_and_irq_priority

/* File: cpu_flags_props.sv */
// Purpose: assertions on flag and priority outputs
// Assumes: mirror outputs lag internal state by one edge
// Notes:   bound to the flag and priority unit
`include "cpu_flags_consts.vh"
`timescale 1ns/1ps
module cpu_flags_props (
	// Clock, reset and stimulus
	input wire        i_clk,
	input wire        i_reset_n,
	input wire [3:0]  i_alu_op,
	input wire [7:0]  i_alu_a,
	input wire [7:0]  i_alu_b,
	input wire [3:0]  i_ctrl_instr,
	input wire        i_irq_ack,
	input wire        i_top_level_interrupt,
	input wire [2:0]  i_branch_cond,
	// Observed outputs
	input wire [7:0]  o_condition_code,
	input wire [31:0] o_spr,
	input wire        o_branch_taken,
	input wire        o_irq_req,
	input wire [3:0]  o_irq_id,
	input wire        o_irq_top
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	wire       plain = i_ctrl_instr == `CI_NONE && !i_irq_ack;
	wire [8:0] sum   = i_alu_a + i_alu_b;
	wire [4:0] nib   = i_alu_a[3:0] + i_alu_b[3:0];
	wire [7:0] cc    = o_condition_code;

	chk_half_add: assert property (i_alu_op == `OP_ADD && plain
		|-> ##2 cc[4] == $past(nib[4], 2)) else $error("half carry");
	chk_carry_add: assert property (i_alu_op == `OP_ADD && plain
		|-> ##2 cc[0] == $past(sum[8], 2)) else $error("carry");
	chk_move_flags: assert property (i_alu_op == `OP_MOVE && plain
		|-> ##2 cc[2:1] == {$past(i_alu_a[7], 2), $past(i_alu_a, 2) == 0})
		else $error("move flags");
	chk_carry_set: assert property (i_ctrl_instr == `CI_SCF
		&& i_alu_op == `OP_NONE |-> ##2 cc[0]) else $error("set carry");
	chk_carry_clear: assert property (i_ctrl_instr == `CI_RCF
		&& i_alu_op == `OP_NONE |-> ##2 !cc[0]) else $error("clear carry");
	chk_branch_carry: assert property (i_branch_cond == `BR_C
		|=> o_branch_taken == cc[0]) else $error("branch on carry");
	chk_irq_entry: assert property (o_irq_req && i_irq_ack && !o_irq_top
		|-> ##2 {cc[5], cc[3]} == 2'($past(o_spr, 2) >> {$past(o_irq_id, 2), 1'b0}))
		else $error("entry level");
	chk_level_block: assert property (({cc[5], cc[3]} == 2'h3
		&& !i_top_level_interrupt)[*3] |-> !o_irq_req) else $error("offer at 3");
	cover property (o_irq_req && i_irq_ack);
	cover property (o_irq_top);
	cover property (o_branch_taken);
endmodule // cpu_flags_props

bind cpu_flags_and_irq_priority cpu_flags_props i_cpu_flags_props (.i_clk,
	.i_reset_n, .i_alu_op, .i_alu_a, .i_alu_b, .i_ctrl_instr, .i_irq_ack,
	.i_top_level_interrupt, .i_branch_cond, .o_condition_code, .o_spr,
	.o_branch_taken,
	.o_irq_req, .o_irq_id, .o_irq_top);

/* File: irq_core_model.sv */
// Purpose: core side that enters offered interrupts
// Assumes: one acknowledge pulse per offer while enabled
// Notes:   enable held low models a slow core
`timescale 1ns/1ps
module irq_core_model (
	// Offer in, acknowledge out
	input  wire i_clk,
	input  wire i_offer,
	input  wire i_enable,
	output reg  o_ack
);
	initial o_ack = 1'b0;
	always @(posedge i_clk) begin
		o_ack <= i_enable && i_offer && !o_ack;
	end
endmodule // irq_core_model

/* File: tb.sv */
// Purpose: self-checking bench for the flag and priority unit
// Assumes: 40 MHz clock, synchronous active-low reset
// Notes:   one task per scenario
`include "cpu_flags_consts.vh"
`timescale 1ns/1ps
module tb;
	reg         i_clk, i_reset_n, acc_en, spr_we, top;
	reg         acc_we, pc_we, nest, shc;
	reg  [15:0] pc_wd;
	reg  [3:0]  op, ci;
	reg  [7:0]  a, b, pop, spr_wd;
	reg  [1:0]  irq_enable_instr, sel;
	reg  [2:0]  bc;
	reg  [13:0] pend, hcap;
	wire [7:0]  cc, acc;
	wire [15:0] pc;
	wire [31:0] spr;
	wire        br, req, itop, halted, waiting, ack;
	wire [3:0]  id;
	integer     fails, checks_done, n;
	cpu_flags_and_irq_priority i_cpu_flags_and_irq_priority (.i_clk(i_clk),
		.i_reset_n(i_reset_n), .i_alu_op(op), .i_alu_a(a), .i_alu_b(b),
		.i_shift_carry(shc), .i_acc_we(acc_we), .i_ctrl_instr(ci),
		.i_pop_data(pop), .i_rim_level(irq_enable_instr), .i_branch_cond(bc),
		.i_spr_we(spr_we), .i_spr_sel(sel), .i_spr_wdata(spr_wd),
		.i_irq_pending(pend), .i_irq_halt_cap(hcap),
		.i_top_level_interrupt(top), .i_nested_mode(nest), .i_irq_ack(ack),
		.i_pc_we(pc_we), .i_pc_wdata(pc_wd), .o_condition_code(cc),
		.o_acc(acc), .o_pc(pc), .o_branch_taken(br), .o_irq_req(req),
		.o_irq_id(id), .o_irq_top(itop), .o_halted(halted),
		.o_waiting(waiting), .o_spr(spr));
	irq_core_model i_irq_core_model (.i_clk(i_clk), .i_offer(req),
		.i_enable(acc_en), .o_ack(ack));
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	task check(input [31:0] seen, input [31:0] exp); begin
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
		end
	end endtask
	task tick(input integer k); repeat (k) @(posedge i_clk); endtask
	task ctl(input [3:0] c, input [7:0] d); begin
		ci <= c; pop <= d; irq_enable_instr <= 2'h2; tick(1); ci <= `CI_NONE; tick(2);
	end endtask
	task alu(input [3:0] o, input [7:0] x, input [7:0] y); begin
		op <= o; a <= x; b <= y; tick(1); op <= `OP_NONE; tick(2);
	end endtask
	task wait_req; begin
		n = 0;
		tick(1);
		while (ack !== 1'b1 && n < 20) begin tick(1); n = n + 1; end
		check(ack, 1); check(req, 1);
	end endtask
	task t_flags; begin
		alu(`OP_ADD, 8'h0F, 8'h01); check(cc & 8'h17, 8'h10);
		alu(`OP_SUB, 8'h00, 8'h01); check(cc & 8'h07, 8'h05);
		alu(`OP_LOGIC, 8'h00, 8'h55); check(cc & 8'h06, 8'h02);
		ctl(`CI_SCF, 8'h00); check(cc & 8'h01, 8'h01);
		alu(`OP_ADC, 8'h08, 8'h07); check(cc & 8'h17, 8'h10);
		ctl(`CI_RCF, 8'h00); check(cc & 8'h01, 8'h00);
		alu(`OP_MOVE, 8'h80, 8'h00); check(cc & 8'h06, 8'h04);
		alu(`OP_ADD, 8'hFF, 8'h01); check(cc & 8'h17, 8'h13);
		for (n = 0; n < 8; n = n + 1) begin
			bc <= n[2:0]; tick(2); check(br, (8'h59 >> n) & 1);
		end
		$display("flag test done");
	end endtask
	task t_irq; begin
		sel <= 2'h1; spr_wd <= 8'hF7; spr_we <= 1'b1; tick(1); spr_we <= 1'b0;
		ctl(`CI_RIM, 8'h00); pend <= 14'h1220; acc_en <= 1'b1;
		wait_req; check(id, 9); acc_en <= 1'b0; pend <= 14'h0020;
		tick(4); check({cc[5], cc[3]}, 2'h3); check(req, 0);
		ctl(`CI_RETURN_FROM_IRQ_INSTR, 8'hE0); acc_en <= 1'b1;
		wait_req; check(id, 5); acc_en <= 1'b0; pend <= 14'h0000;
		tick(4); check({cc[5], cc[3]}, 2'h1); ctl(`CI_RETURN_FROM_IRQ_INSTR, 8'hE0);
		$display("priority test done");
	end endtask
	task t_halt; begin
		ctl(`CI_HALT, 8'h00); check(halted, 1);
		pend <= 14'h0004; tick(4); check(halted, 1); check(req, 0);
		hcap <= 14'h0080; pend <= 14'h0084; acc_en <= 1'b1;
		wait_req; check(id, 7); acc_en <= 1'b0; pend <= 14'h0004;
		tick(4); ctl(`CI_RETURN_FROM_IRQ_INSTR, 8'hE0); acc_en <= 1'b1;
		wait_req; check(id, 2); acc_en <= 1'b0; pend <= 14'h0000;
		tick(4); ctl(`CI_RETURN_FROM_IRQ_INSTR, 8'hE0); hcap <= 14'h0000;
		ctl(`CI_WFI, 8'h00); check(waiting, 1);
		pend <= 14'h2000; tick(4); check(waiting, 0); pend <= 0;
		top <= 1'b1; tick(4); check(itop, 1); top <= 1'b0;
		$display("low power test done");
	end endtask
	task t_regs; begin
		op <= `OP_ADD; a <= 8'h12; b <= 8'h34; acc_we <= 1'b1; tick(1);
		op <= `OP_NONE; acc_we <= 1'b0; tick(2); check(acc, 8'h46);
		pc_wd <= 16'hA55A; pc_we <= 1'b1; tick(1); pc_we <= 1'b0;
		tick(2); check(pc, 16'hA55A);
		shc <= 1'b1; alu(`OP_SHIFT, 8'h80, 8'h00); shc <= 1'b0;
		check(cc & 8'h07, 8'h05);
		nest <= 1'b1; pend <= 14'h0020; acc_en <= 1'b1;
		wait_req; check(id, 5); acc_en <= 1'b0; pend <= 14'h0024;
		tick(1); acc_en <= 1'b1;
		wait_req; check(id, 2); acc_en <= 1'b0; pend <= 14'h0000;
		nest <= 1'b0; tick(4); check({cc[5], cc[3]}, 2'h3);
		ctl(`CI_RETURN_FROM_IRQ_INSTR, 8'hE0);
		$display("register and nesting test done");
	end endtask
	task tally_and_finish; begin
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end endtask
	initial begin
		fails = 0; checks_done = 0; i_reset_n = 0; acc_en = 0; spr_we = 0;
		top = 0; op = 0; ci = 0; a = 0; b = 0; pop = 0; spr_wd = 0; irq_enable_instr = 0;
		sel = 0; bc = 0; pend = 0; hcap = 0;
		acc_we = 0; pc_we = 0; nest = 0; shc = 0; pc_wd = 0;
		tick(12); i_reset_n <= 1'b1; tick(1);
		check(cc, 8'hE8); check(spr, 32'hFFFFFFFF); check(pc | acc, 0);
		t_flags; t_irq; t_halt; t_regs;
		tally_and_finish;
	end
	initial begin
		#(25 * 4000);
		fails = fails + 1;
		tally_and_finish;
	end
endmodule // tb
